// [rsr_host_model.sv]
// behavioural host processor issuing i/o cycles to the block
module rsr_host_model (
    // clock and answer
    input wire logic ref_clk,
    input wire logic io_ready,
    // request
    output logic io_req,
    output rsr_pkg::rsr_io_req_t io_cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        io_req = 1'b0;
        io_cmd = '0;
    end
    // held until ready is seen or 20 cycles pass; inverted when idle so no stale command helps
    task automatic access(input rsr_pkg::rsr_io_req_t cmd, input int gap,
                          output bit ok);
        ok = 1'b0;
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        #1 io_req = 1'b1;
        io_cmd = cmd;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(negedge ref_clk);
            ok = (io_ready === 1'b1);
        end
        @(posedge ref_clk);
        #1 io_req = 1'b0;
        io_cmd = ~cmd;
    endtask
endmodule

// [rsr_pkg.sv]
// constants, types and pin reset states for the reset/register-access block
package rsr_pkg;
    localparam logic [15:0] CFG_ADDR_PORT = 16'h0cf8;
    localparam logic [15:0] CFG_DATA_PORT = 16'h0cfc;
    localparam int CFG_ENABLE_BIT = 31;
    localparam logic [31:0] CFG_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_ADDR_MASK = 32'h80ff_fffc;
    localparam logic [3:0] BE_DWORD = 4'hf;
    localparam int CFG_WORDS = 64;
    localparam logic [5:0] IDX_ID = 6'h00;
    localparam logic [5:0] IDX_CMD = 6'h01;
    localparam logic [5:0] IDX_CLASS = 6'h02;
    localparam logic [5:0] IDX_DEV_LO = 6'h10;
    localparam logic [5:0] IDX_UNDEF_LO = 6'h30;
    // identity value is arbitrary
    localparam logic [31:0] ID_VALUE = 32'h5a5a_0001;
    localparam logic [31:0] CLASS_VALUE = 32'h0600_0000;
    localparam logic [31:0] CMD_DEFAULT = 32'h0000_0006;
    localparam logic [31:0] DEV_DEFAULT = 32'h0000_0000;
    localparam logic [31:0] UNDEF_VALUE = 32'hffff_ffff;
    localparam logic [31:0] NO_TARGET_VALUE = 32'hffff_ffff;
    localparam logic [31:0] CMD_RW_MASK = 32'h0000_ffff;
    localparam logic [31:0] CMD_RWC_MASK = 32'hffff_0000;

    typedef enum logic [1:0] {
        RSR_IDLE = 2'b01,
        RSR_ANSWER = 2'b10
    } rsr_state_t;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } rsr_io_req_t;

    typedef struct packed {
        logic addr_oe;
        logic addr_hold;
        logic burst_ready_n;
        logic next_address_n;
        logic external_strobe_n;
        logic backoff_n;
        logic cacheable_invalidate;
        logic [5:0] ras_cs_n;
        logic [1:0] sdram_cke;
        logic tag_write_enable_n;
        logic tag_oe;
        logic sram_select_n;
        logic sram_output_enable_n;
        logic global_write_n;
        logic byte_write_n;
        logic sram_strobe_n;
        logic sram_advance_n;
        logic pci_ad_oe;
        logic gnt_oe;
        logic passive_hold_ack_n;
        logic par_level;
    } rsr_pin_ctl_t;

    // driven levels while the hard reset is held
    localparam rsr_pin_ctl_t PINS_DURING = '{
        addr_oe: 1'b1, addr_hold: 1'b1, burst_ready_n: 1'b1,
        next_address_n: 1'b1, external_strobe_n: 1'b1, backoff_n: 1'b1,
        cacheable_invalidate: 1'b0, ras_cs_n: 6'h00, sdram_cke: 2'h0,
        tag_write_enable_n: 1'b0, tag_oe: 1'b1, sram_select_n: 1'b0,
        sram_output_enable_n: 1'b1, global_write_n: 1'b1,
        byte_write_n: 1'b1, sram_strobe_n: 1'b1, sram_advance_n: 1'b1,
        pci_ad_oe: 1'b1, gnt_oe: 1'b0, passive_hold_ack_n: 1'b1,
        par_level: 1'b0};

    // levels once the reset has been released
    localparam rsr_pin_ctl_t PINS_AFTER = '{
        addr_oe: 1'b0, addr_hold: 1'b0, burst_ready_n: 1'b1,
        next_address_n: 1'b1, external_strobe_n: 1'b1, backoff_n: 1'b1,
        cacheable_invalidate: 1'b0, ras_cs_n: 6'h3f, sdram_cke: 2'h3,
        tag_write_enable_n: 1'b1, tag_oe: 1'b0, sram_select_n: 1'b0,
        sram_output_enable_n: 1'b1, global_write_n: 1'b1,
        byte_write_n: 1'b1, sram_strobe_n: 1'b1, sram_advance_n: 1'b1,
        pci_ad_oe: 1'b0, gnt_oe: 1'b1, passive_hold_ack_n: 1'b1,
        par_level: 1'b0};
endpackage

// [rsr_reset_regs.sv]
// pin states around hard reset and host register access for the controller
module rsr_reset_regs (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // host i/o access port
    input wire logic io_req,
    input wire rsr_pkg::rsr_io_req_t io_cmd,
    output logic io_ready,
    output logic [31:0] io_rdata,
    // hardware events into the status half of the command word
    input wire logic [15:0] status_set,
    // host bus pins
    output logic [31:3] host_addr_out,
    output logic [31:3] host_addr_oe,
    input wire logic [31:3] host_addr_in,
    output logic host_burst_ready_n,
    output logic host_next_address_n,
    output logic host_address_hold,
    output logic host_external_strobe_n,
    output logic host_backoff_n,
    output logic host_cacheable_invalidate,
    output logic [63:0] host_data_bus_out,
    output logic [63:0] host_data_bus_oe,
    input wire logic [63:0] host_data_bus_in,
    // memory pins
    output logic [63:0] memory_data_bus_out,
    output logic [63:0] memory_data_bus_oe,
    input wire logic [63:0] memory_data_bus_in,
    output logic [5:0] ras_cs_n,
    output logic [1:0] sdram_cke,
    // tag and cache sram pins
    output logic tag_write_enable_n,
    output logic [7:0] tag_data_out,
    output logic [7:0] tag_data_oe,
    input wire logic [7:0] tag_data_in,
    output logic cache_sram_select_n,
    output logic cache_sram_output_enable_n,
    output logic cache_global_write_n,
    output logic cache_byte_write_n,
    output logic cache_address_strobe_n,
    output logic cache_address_advance_n,
    // pci pins
    output logic [31:0] pci_ad_out,
    output logic [31:0] pci_ad_oe,
    input wire logic [31:0] pci_ad_in,
    output logic [3:0] pci_cbe_n_out,
    output logic [3:0] pci_cbe_n_oe,
    output logic [5:0] pci_ctl_n_out,
    output logic [5:0] pci_ctl_n_oe,
    output logic [3:0] pci_gnt_n_out,
    output logic [3:0] pci_gnt_n_oe,
    output logic passive_hold_ack_n,
    output logic pci_par_out,
    output logic pci_par_oe
);
    rsr_pkg::rsr_pin_ctl_t pins_ff;
    rsr_pkg::rsr_state_t state_ff;
    rsr_pkg::rsr_state_t nxt_state;
    logic [31:0] cfg_addr_ff;
    logic [31:0] nxt_cfg_addr;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] cfg_mem_ff [rsr_pkg::CFG_WORDS];
    logic [31:0] nxt_cfg [rsr_pkg::CFG_WORDS];

    // default contents per configuration word
    function automatic logic [31:0] def_word(input logic [5:0] idx);
        if (idx == rsr_pkg::IDX_ID) begin
            def_word = rsr_pkg::ID_VALUE;
        end else if (idx == rsr_pkg::IDX_CMD) begin
            def_word = rsr_pkg::CMD_DEFAULT;
        end else if (idx == rsr_pkg::IDX_CLASS) begin
            def_word = rsr_pkg::CLASS_VALUE;
        end else begin
            def_word = rsr_pkg::DEV_DEFAULT;
        end
    endfunction

    function automatic logic is_dev_word(input logic [5:0] idx);
        is_dev_word = (idx >= rsr_pkg::IDX_DEV_LO) &&
                      (idx < rsr_pkg::IDX_UNDEF_LO);
    endfunction

    // bits that software may write plainly
    function automatic logic [31:0] rw_mask(input logic [5:0] idx);
        if (idx == rsr_pkg::IDX_CMD) begin
            rw_mask = rsr_pkg::CMD_RW_MASK;
        end else if (is_dev_word(idx)) begin
            rw_mask = 32'hffff_ffff;
        end else begin
            rw_mask = 32'h0000_0000;
        end
    endfunction

    // bits that a written one clears
    function automatic logic [31:0] rwc_mask(input logic [5:0] idx);
        rwc_mask = (idx == rsr_pkg::IDX_CMD) ? rsr_pkg::CMD_RWC_MASK
                                             : 32'h0000_0000;
    endfunction

    // byte lane i carries the byte at address offset i
    function automatic logic [31:0] lanes(input logic [3:0] be);
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] read_word(input logic [5:0] idx,
                                              input logic [31:0] stored);
        if (idx >= rsr_pkg::IDX_UNDEF_LO) begin
            read_word = rsr_pkg::UNDEF_VALUE;
        end else if (idx > rsr_pkg::IDX_CLASS && idx < rsr_pkg::IDX_DEV_LO)
        begin
            read_word = 32'h0000_0000;
        end else begin
            read_word = stored;
        end
    endfunction

    // decode of the host access; no pci-side path exists at all
    wire logic take = io_req && (state_ff == rsr_pkg::RSR_IDLE);
    wire logic hit_addr_port = io_cmd.addr == rsr_pkg::CFG_ADDR_PORT;
    wire logic hit_data_port = io_cmd.addr == rsr_pkg::CFG_DATA_PORT;
    wire logic is_dword = io_cmd.be == rsr_pkg::BE_DWORD;
    // narrower accesses to the address port pass by it
    wire logic addr_access = hit_addr_port && is_dword;
    wire logic cfg_enabled = cfg_addr_ff[rsr_pkg::CFG_ENABLE_BIT];
    wire logic own_target = (cfg_addr_ff[23:8] == 16'h0000);
    // window reaches config space only while enabled
    wire logic cfg_access = hit_data_port && cfg_enabled && own_target;
    wire logic [5:0] cfg_idx = cfg_addr_ff[7:2];
    wire logic [31:0] lane_mask = lanes(io_cmd.be);
    wire logic [31:0] cur_word = cfg_mem_ff[cfg_idx];
    wire logic [31:0] wr_bits = rw_mask(cfg_idx) & lane_mask;
    wire logic [31:0] clr_bits = rwc_mask(cfg_idx) & lane_mask;
    wire logic cfg_write = take && io_cmd.wr && cfg_access;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rsr_pkg::RSR_IDLE: begin
                if (take) begin
                    nxt_state = rsr_pkg::RSR_ANSWER;
                end
            end
            rsr_pkg::RSR_ANSWER: begin
                nxt_state = rsr_pkg::RSR_IDLE;
            end
            default: begin
                nxt_state = rsr_pkg::RSR_IDLE;
            end
        endcase
    end

    // reserved address bits never store, so they read back zero
    always_comb begin
        nxt_cfg_addr = cfg_addr_ff;
        if (take && io_cmd.wr && addr_access) begin
            nxt_cfg_addr = io_cmd.wdata & rsr_pkg::CFG_ADDR_MASK;
        end
    end

    // every access completes; reads pick by target
    always_comb begin
        nxt_rdata = rdata_ff;
        if (take) begin
            nxt_rdata = 32'h0000_0000;
            if (!io_cmd.wr) begin
                if (addr_access) begin
                    nxt_rdata = cfg_addr_ff;
                end else if (cfg_access) begin
                    // reserved reads zero, undefined non-zero
                    nxt_rdata = read_word(cfg_idx, cur_word) & lane_mask;
                end else if (hit_data_port) begin
                    nxt_rdata = rsr_pkg::NO_TARGET_VALUE & lane_mask;
                end
            end
        end
    end

    // read-only words have empty write masks, so writes leave them
    always_comb begin
        for (int i = 0; i < rsr_pkg::CFG_WORDS; i++) begin
            nxt_cfg[i] = cfg_mem_ff[i];
        end
        if (cfg_write) begin
            nxt_cfg[cfg_idx] = (cur_word & ~wr_bits) |
                               (io_cmd.wdata & wr_bits);
            // a written one clears, a zero
            nxt_cfg[cfg_idx] = nxt_cfg[cfg_idx] & ~(io_cmd.wdata & clr_bits);
        end
        // a status event in the clearing cycle still lands: set wins
        nxt_cfg[rsr_pkg::IDX_CMD] = nxt_cfg[rsr_pkg::IDX_CMD] |
                                    {status_set, 16'h0000};
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= rsr_pkg::RSR_IDLE;
            cfg_addr_ff <= rsr_pkg::CFG_ADDR_RESET;
            rdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cfg_addr_ff <= nxt_cfg_addr;
            rdata_ff <= nxt_rdata;
        end
    end

    // every config word loads its fixed default
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < rsr_pkg::CFG_WORDS; i++) begin
                cfg_mem_ff[i] <= def_word(6'(i));
            end
        end else if (clk_en) begin
            for (int i = 0; i < rsr_pkg::CFG_WORDS; i++) begin
                cfg_mem_ff[i] <= nxt_cfg[i];
            end
        end
    end

    // pin levels: reset value is the in-reset state, first enabled edge moves on
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_ff <= rsr_pkg::PINS_DURING;
        end else if (clk_en) begin
            pins_ff <= rsr_pkg::PINS_AFTER;
        end
    end

    assign io_ready = (state_ff == rsr_pkg::RSR_ANSWER);
    assign io_rdata = rdata_ff;

    // host bus side
    assign host_addr_out = '0;
    assign host_addr_oe = {29{pins_ff.addr_oe}};
    assign host_address_hold = pins_ff.addr_hold;
    assign host_burst_ready_n = pins_ff.burst_ready_n;
    assign host_next_address_n = pins_ff.next_address_n;
    assign host_external_strobe_n = pins_ff.external_strobe_n;
    assign host_backoff_n = pins_ff.backoff_n;
    assign host_cacheable_invalidate = pins_ff.cacheable_invalidate;
    // data buses stay released; transfer logic lives elsewhere
    assign host_data_bus_out = '0;
    assign host_data_bus_oe = '0;
    assign memory_data_bus_out = '0;
    assign memory_data_bus_oe = '0;

    // memory controls: driven low in reset rather than left floating
    assign ras_cs_n = pins_ff.ras_cs_n;
    assign sdram_cke = pins_ff.sdram_cke;

    // tag and cache sram
    assign tag_write_enable_n = pins_ff.tag_write_enable_n;
    assign tag_data_out = '0;
    assign tag_data_oe = {8{pins_ff.tag_oe}};
    assign cache_sram_select_n = pins_ff.sram_select_n;
    assign cache_sram_output_enable_n = pins_ff.sram_output_enable_n;
    assign cache_global_write_n = pins_ff.global_write_n;
    assign cache_byte_write_n = pins_ff.byte_write_n;
    assign cache_address_strobe_n = pins_ff.sram_strobe_n;
    assign cache_address_advance_n = pins_ff.sram_advance_n;

    // pci side
    assign pci_ad_out = '0;
    assign pci_ad_oe = {32{pins_ff.pci_ad_oe}};
    assign pci_cbe_n_out = '0;
    assign pci_cbe_n_oe = {4{pins_ff.pci_ad_oe}};
    assign pci_ctl_n_out = 6'h3f;
    assign pci_ctl_n_oe = 6'h00;
    assign pci_gnt_n_out = 4'hf;
    assign pci_gnt_n_oe = {4{pins_ff.gnt_oe}};
    assign passive_hold_ack_n = pins_ff.passive_hold_ack_n;
    // parity kept low after reset too: any driven level is allowed
    assign pci_par_out = pins_ff.par_level;
    assign pci_par_oe = 1'b1;
endmodule

// [rsr_reset_regs_monitor.sv]
// concurrent checks of pin states after reset and host port timing
module rsr_reset_regs_monitor (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // host port
    input wire logic io_req,
    input wire logic io_ready,
    // host, memory and tag pins
    input wire logic [31:3] host_addr_oe,
    input wire logic host_address_hold,
    input wire logic host_burst_ready_n,
    input wire logic host_next_address_n,
    input wire logic host_external_strobe_n,
    input wire logic host_backoff_n,
    input wire logic host_cacheable_invalidate,
    input wire logic [63:0] host_data_bus_oe,
    input wire logic [63:0] memory_data_bus_oe,
    input wire logic [5:0] ras_cs_n,
    input wire logic [1:0] sdram_cke,
    input wire logic tag_write_enable_n,
    input wire logic [7:0] tag_data_oe,
    // cache sram pins
    input wire logic cache_sram_select_n,
    input wire logic cache_sram_output_enable_n,
    input wire logic cache_global_write_n,
    input wire logic cache_byte_write_n,
    input wire logic cache_address_strobe_n,
    input wire logic cache_address_advance_n,
    // pci pins
    input wire logic [31:0] pci_ad_oe,
    input wire logic [3:0] pci_cbe_n_oe,
    input wire logic [5:0] pci_ctl_n_oe,
    input wire logic [3:0] pci_gnt_n_out,
    input wire logic [3:0] pci_gnt_n_oe,
    input wire logic passive_hold_ack_n,
    input wire logic pci_par_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // pins move on the first enabled edge after release, seen one edge later
    sequence s_rel; $past(arst_n) && $past(clk_en); endsequence
    sequence s_take; io_req && clk_en && !io_ready; endsequence
    sequence s_answer; io_ready; endsequence
    property p_addr; s_rel |-> host_addr_oe == 29'h0; endproperty
    a_addr: assert property (p_addr) else $error("address driven");
    property p_hold; s_rel |-> !host_address_hold; endproperty
    a_hold: assert property (p_hold) else $error("hold high");
    property p_ctl; host_burst_ready_n && host_next_address_n
        && host_external_strobe_n && host_backoff_n; endproperty
    a_ctl: assert property (p_ctl) else $error("host strobe low");
    property p_data; !host_cacheable_invalidate && host_data_bus_oe == 64'h0
        && memory_data_bus_oe == 64'h0; endproperty
    a_data: assert property (p_data) else $error("data driven");
    property p_ras; s_rel |-> ras_cs_n == 6'h3f; endproperty
    a_ras: assert property (p_ras) else $error("row strobe low");
    property p_cke; s_rel |-> sdram_cke == 2'h3; endproperty
    a_cke: assert property (p_cke) else $error("clock enable low");
    property p_tag; s_rel |-> tag_write_enable_n && tag_data_oe == 8'h00;
    endproperty
    a_tag: assert property (p_tag) else $error("tag pins wrong");
    property p_pci; s_rel |-> pci_ad_oe == 32'h0 && pci_cbe_n_oe == 4'h0
        && pci_ctl_n_oe == 6'h00; endproperty
    a_pci: assert property (p_pci) else $error("pci lines driven");
    property p_gnt; s_rel |-> pci_gnt_n_oe == 4'hf && pci_gnt_n_out == 4'hf
        && passive_hold_ack_n; endproperty
    a_gnt: assert property (p_gnt) else $error("grant wrong");
    property p_par; pci_par_oe; endproperty
    a_par: assert property (p_par) else $error("parity floats");
    property p_sram; !cache_sram_select_n && cache_sram_output_enable_n
        && cache_global_write_n && cache_byte_write_n
        && cache_address_strobe_n && cache_address_advance_n; endproperty
    a_sram: assert property (p_sram) else $error("sram pins wrong");
    property p_answer; s_take |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; io_ready && clk_en |=> !io_ready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
endmodule

// [test_rsr_reset_regs.sv]
// self-checking bench for reset pin states and host register access
bind rsr_reset_regs rsr_reset_regs_monitor u_mon (.*);
module test_rsr_reset_regs;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] A = rsr_pkg::CFG_ADDR_PORT;
    localparam logic [15:0] D = rsr_pkg::CFG_DATA_PORT;
    logic ref_clk, arst_n, clk_en, io_req, io_ready, host_address_hold;
    logic tag_write_enable_n, pci_par_out, pci_par_oe;
    rsr_pkg::rsr_io_req_t io_cmd;
    logic [31:0] io_rdata, pci_ad_out, pci_ad_oe, d, r;
    logic [15:0] status_set;
    logic [31:3] host_addr_out, host_addr_oe;
    logic [63:0] rnd_a, rnd_b;
    logic [5:0] ras_cs_n, pci_ctl_n_oe;
    logic [1:0] sdram_cke;
    logic [7:0] tag_data_oe, tag_data_out;
    logic [5:0] sram_pins;
    logic [3:0] pci_cbe_n_out, pci_cbe_n_oe, pci_gnt_n_oe;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [5:0] idx_tab [5] = '{rsr_pkg::IDX_ID, rsr_pkg::IDX_CLASS, 6'h05,
        rsr_pkg::IDX_UNDEF_LO, rsr_pkg::IDX_DEV_LO};
    logic [31:0] dflt [5] = '{rsr_pkg::ID_VALUE, rsr_pkg::CLASS_VALUE, 32'h0,
        rsr_pkg::UNDEF_VALUE, rsr_pkg::DEV_DEFAULT};
    int errors;
    int total_checks;
    bit ok;
    rsr_host_model u_host (.ref_clk, .io_ready, .io_req, .io_cmd);
    rsr_reset_regs dut (.ref_clk, .arst_n, .clk_en, .io_req, .io_cmd,
        .io_ready, .io_rdata, .status_set, .host_addr_out, .host_addr_oe,
        .host_addr_in(rnd_a[31:3]), .host_burst_ready_n(),
        .host_next_address_n(), .host_address_hold, .host_backoff_n(),
        .host_external_strobe_n(), .host_cacheable_invalidate(),
        .host_data_bus_out(), .host_data_bus_oe(), .host_data_bus_in(rnd_a),
        .memory_data_bus_out(), .memory_data_bus_oe(),
        .memory_data_bus_in(rnd_b), .ras_cs_n, .sdram_cke,
        .tag_write_enable_n, .tag_data_out, .tag_data_oe,
        .tag_data_in(rnd_b[7:0]), .cache_sram_select_n(sram_pins[5]),
        .cache_sram_output_enable_n(sram_pins[4]),
        .cache_global_write_n(sram_pins[3]),
        .cache_byte_write_n(sram_pins[2]),
        .cache_address_strobe_n(sram_pins[1]),
        .cache_address_advance_n(sram_pins[0]), .pci_ad_out, .pci_ad_oe,
        .pci_ad_in(rnd_b[31:0]), .pci_cbe_n_out, .pci_cbe_n_oe,
        .pci_ctl_n_out(), .pci_ctl_n_oe, .pci_gnt_n_out(), .pci_gnt_n_oe,
        .passive_hold_ack_n(), .pci_par_out, .pci_par_oe);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lanes(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction
    task automatic check_pin(input string name, input logic [63:0] exp,
                             input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_rdata(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR io_rdata expected %h seen %h", exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reads leave their expected data in the queue for the watcher
    task automatic acc(input logic wr, input logic [15:0] a,
                       input logic [3:0] be, input logic [31:0] w,
                       input logic [31:0] exp);
        if (wr) exp_q.push_back(33'h0);
        else exp_q.push_back({1'b1, exp & lanes(be)});
        u_host.access({wr, a, be, w}, $urandom_range(0, 2), ok);
        if (!ok) begin
            errors++;
            complete_run();
        end
    endtask
    task automatic sel(input logic [5:0] idx);
        acc(1'b1, A, 4'hf, {8'h80, 16'h0, idx, 2'b00}, 32'h0);
    endtask
    always @(negedge ref_clk) begin
        if (io_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_pin("io_ready", 64'h0, 64'h1);
            end else begin
                note = exp_q.pop_front();
            end
            if (note[32]) check_rdata(note[31:0], io_rdata);
            note = 33'h0;
        end
    end
    initial begin
        errors = 0;
        total_checks = 0;
        note = 33'h0;
        r = $urandom(6);
        rnd_a = {$urandom, $urandom};
        rnd_b = {$urandom, $urandom};
        arst_n = 1'b0;
        clk_en = 1'b1;
        status_set = 16'h0;
        repeat (3) @(posedge ref_clk);
        check_pin("addr", 64'h1fff_ffff, host_addr_oe);
        check_pin("addr_out", 64'h0, host_addr_out);
        check_pin("hold", 64'h1, host_address_hold);
        check_pin("tag", 64'h0ff00,
            {tag_write_enable_n, tag_data_oe, tag_data_out});
        check_pin("sram", 64'h1f, sram_pins);
        check_pin("pci_oe", 64'hf_ffff_ffff,
            {pci_ctl_n_oe, pci_ad_oe, pci_cbe_n_oe});
        check_pin("pci_out", 64'h0, {pci_ad_out, pci_cbe_n_out});
        check_pin("gnt", 64'h0, pci_gnt_n_oe);
        check_pin("par", 64'h2, {pci_par_oe, pci_par_out});
        check_pin("driven", 64'h0,
            $isunknown({ras_cs_n, sdram_cke, pci_par_out}));
        #1 arst_n = 1'b1;
        clk_en = 1'b0;
        // a frozen block keeps its reset levels until enabled
        repeat (2) @(posedge ref_clk);
        check_pin("hold_frozen", 64'h1, host_address_hold);
        #1 clk_en = 1'b1;
        acc(1'b0, A, 4'hf, 32'h0, rsr_pkg::CFG_ADDR_RESET);
        check_pin("addr_rel", 64'h0, host_addr_oe);
        check_pin("hold_rel", 64'h0, host_address_hold);
        check_pin("mem_rel", 64'hff, {ras_cs_n, sdram_cke});
        check_pin("tag_rel", 64'h100,
            {tag_write_enable_n, tag_data_oe});
        check_pin("pci_rel", 64'h0, {pci_ad_oe, pci_cbe_n_oe});
        check_pin("gnt_rel", 64'hf, pci_gnt_n_oe);
        check_pin("sram_rel", 64'h1f, sram_pins);
        r = $urandom & rsr_pkg::CFG_ADDR_MASK;
        acc(1'b1, A, 4'hf, r, 32'h0);
        acc(1'b0, A, 4'hf, 32'h0, r);
        acc(1'b0, A, 4'h3, 32'h0, 32'h0);
        acc(1'b1, A, 4'hf, 32'h0000_0040, 32'h0);
        acc(1'b0, D, 4'hf, 32'h0, rsr_pkg::NO_TARGET_VALUE);
        sel(6'h00);
        acc(1'b1, A, 4'h1, 32'h0000_00ff, 32'h0);
        acc(1'b0, A, 4'hf, 32'h0, 32'h8000_0000);
        for (int i = 0; i < 5; i++) begin
            sel(idx_tab[i]);
            acc(1'b0, D, 4'hf, 32'h0, dflt[i]);
            d = $urandom;
            if (i != 3) acc(1'b1, D, 4'hf, d, 32'h0);
            r = (i == 4) ? d : dflt[i];
            acc(1'b0, D, 4'hf, 32'h0, r);
        end
        acc(1'b0, D, 4'h4, 32'h0, d);
        acc(1'b1, D, 4'h2, ~d, 32'h0);
        acc(1'b0, D, 4'hf, 32'h0, {d[31:16], ~d[15:8], d[7:0]});
        sel(rsr_pkg::IDX_CMD);
        acc(1'b0, D, 4'hf, 32'h0, rsr_pkg::CMD_DEFAULT);
        @(posedge ref_clk);
        #1 status_set = d[31:16];
        @(posedge ref_clk);
        #1 status_set = 16'h0;
        acc(1'b1, D, 4'h3, ~d, 32'h0);
        acc(1'b0, D, 4'hf, 32'h0, {d[31:16], ~d[15:0]});
        r = $urandom;
        acc(1'b1, D, 4'hc, r, 32'h0);
        acc(1'b0, D, 4'hf, 32'h0, {d[31:16] & ~r[31:16], ~d[15:0]});
        acc(1'b0, 16'h0080, 4'hf, 32'h0, 32'h0);
        @(posedge ref_clk);
        #1 arst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        check_pin("hold_again", 64'h1, host_address_hold);
        check_pin("addr_again", 64'h1fff_ffff, host_addr_oe);
        #1 arst_n = 1'b1;
        acc(1'b0, A, 4'hf, 32'h0, rsr_pkg::CFG_ADDR_RESET);
        repeat (3) @(posedge ref_clk);
        check_pin("queue", 64'h0, exp_q.size());
        complete_run();
    end
endmodule
